/* File: src/burner_option_pkg.sv */
package burner_option_pkg;

   // timing
   localparam longint CLK_HZ = 50_000_000;
   localparam longint DEBOUNCE_MS = 10;
   localparam longint DEBOUNCE_CYCLES = (CLK_HZ / 1000) * DEBOUNCE_MS;
   localparam longint DIM_TIME_S = 120;
   localparam longint DIM_CYCLES = CLK_HZ * DIM_TIME_S;
   localparam longint FLASH_HALF_MS = 500;
   localparam longint FLASH_HALF_CYCLES = (CLK_HZ / 1000) * FLASH_HALF_MS;

   // register map (byte addresses)
   localparam int ADDR_W = 8;
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_IRQ_STATUS = 8'h04;
   localparam logic [7:0] REG_IRQ_CLEAR = 8'h08;
   localparam logic [7:0] REG_IRQ_ENABLE = 8'h0C;
   localparam logic [7:0] REG_CONTROL = 8'h10;

   // interrupt status bits
   localparam int IRQ_W = 4;
   localparam int IRQ_PF = 0;
   localparam int IRQ_HT = 1;
   localparam int IRQ_SD = 2;
   localparam int IRQ_RUN = 3;
   localparam logic [IRQ_W-1:0] IRQ_ENABLE_RST = 4'h0;

   // control register
   localparam int CTRL_REMOTE_RUN = 0;
   localparam logic CTRL_REMOTE_RUN_RST = 1'b1;

   // status register fields
   localparam int ST_STATE_LSB = 0;
   localparam int ST_PERMIT = 6;
   localparam int ST_PILOT = 7;
   localparam int ST_DIM = 8;
   localparam int ST_SW_LSB = 9;

   // synchronised input vector layout
   localparam int IN_W = 18;
   localparam int IN_PF_LATCH = 0;
   localparam int IN_OVERTEMP_LATCH_SEL = 1;
   localparam int IN_SHUTDOWN_LATCH_SEL = 2;
   localparam int IN_PILOT_MODE = 3;
   localparam int IN_DIM_SEL = 4;
   localparam int IN_SEC_RANGE = 5;
   localparam int IN_SEC_EN = 6;
   localparam int IN_PRI_RANGE = 7;
   localparam int IN_LOCAL_ON = 8;
   localparam int IN_REMOTE_ON = 9;
   localparam int IN_SHUTDOWN = 10;
   localparam int IN_LEVEL_SD = 11;
   localparam int IN_POC = 12;
   localparam int IN_PRI_BELOW = 13;
   localparam int IN_PRI_OVER = 14;
   localparam int IN_SEC_OVER = 15;
   localparam int IN_KEYPAD = 16;
   localparam int IN_FLAME = 17;
   localparam int SW_W = 8;

   // switch defaults, starts off, shutdowns on: nothing runs before sampling
   localparam logic [IN_W-1:0] IN_RST = 18'h0_1C46;

   typedef enum logic [5:0] {
      ST_POWERUP = 6'b00_0001,
      ST_WAIT = 6'b00_0010,
      ST_RUN = 6'b00_0100,
      ST_PF_LATCH = 6'b00_1000,
      ST_OVERTEMP_LATCH_SEL = 6'b01_0000,
      ST_SHUTDOWN_LATCH_SEL = 6'b10_0000
   } ctrl_state_e;

endpackage

/* File: src/burner_option_switch_logic.sv */
`timescale 1ns/1ps
// Functional notes
// - power-fail latch off: restart after power-up when clear.
// - power-fail latch on: hold until start toggles, flash code.
// - overtemp latch off: retry when selected sensor temperature falls.
// - overtemp latch on: hold until start toggles, flash code.
// - shutdown latch off: retry once both shutdowns clear.
// - shutdown latch on: hold until start toggles, flash code.
// - intermittent pilot: solenoid on while primary below setpoint.
// - continuous pilot: solenoid on throughout run.
// - power save off: never dim.
// - power save on: dim when idle, sensor LEDs off, flame LED kept.
// - keypad press restores brightness, restarts idle time.
// - secondary range switch: off wide, on narrow span.
// - secondary disabled: overtemp from primary only.
// - secondary enabled: overtemp from secondary.
// - primary range switch off: wide span.
// - primary range switch on: narrow span.
// - switch right reads on, left off.
module burner_option_switch_logic #(
   parameter longint DEBOUNCE_CYCLES = burner_option_pkg::DEBOUNCE_CYCLES,
   parameter longint DIM_CYCLES = burner_option_pkg::DIM_CYCLES,
   parameter longint FLASH_HALF_CYCLES = burner_option_pkg::FLASH_HALF_CYCLES
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic clk_en,
   // option switches, high = slid right
   input wire logic power_fail_latch_sel,
   input wire logic overtemp_latch_sel,
   input wire logic shutdown_latch_sel,
   input wire logic pilot_continuous_sel,
   input wire logic display_dim_sel,
   input wire logic secondary_sensor_range_sel,
   input wire logic secondary_sensor_enable,
   input wire logic primary_sensor_range_sel,
   // start sources and plant inputs
   input wire logic local_on,
   input wire logic remote_on,
   input wire logic shutdown_active,
   input wire logic level_shutdown_active,
   input wire logic proof_of_closure_input,
   input wire logic primary_sensor_below_sp,
   input wire logic primary_sensor_over_sp,
   input wire logic secondary_sensor_over_sp,
   input wire logic keypad_press,
   input wire logic flame_present,
   // same-clock status
   input wire logic powerup_done,
   input wire logic other_fault,
   // register port
   input wire logic [burner_option_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic irq,
   // outputs
   output logic ignition_permit,
   output logic pilot_solenoid_en,
   output logic display_dim,
   output logic sensor_select_led_en,
   output logic ignition_led_on,
   output logic power_fail_flash_code,
   output logic overtemp_flash_code,
   output logic shutdown_flash_code,
   output logic primary_narrow_range,
   output logic secondary_narrow_range,
   output logic secondary_sensor_used
);

   localparam int DEB_W = $clog2(DEBOUNCE_CYCLES + 1);
   localparam int DIM_W = $clog2(DIM_CYCLES + 1);
   localparam int FL_W = $clog2(FLASH_HALF_CYCLES + 1);
   localparam int IN_W = burner_option_pkg::IN_W;

   initial begin
      if (DEBOUNCE_CYCLES < 1 || DIM_CYCLES < 1 || FLASH_HALF_CYCLES < 1) begin
         $error("count below one");
      end
   end

   function automatic logic at_limit(input logic [63:0] cnt, input longint lim);
      at_limit = (cnt >= 64'(lim - 1));
   endfunction

   function automatic logic reg_hit(input logic strobe,
                                    input logic [burner_option_pkg::ADDR_W-1:0] a,
                                    input logic [7:0] off);
      reg_hit = strobe && (a == off);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // synchronise and debounce

   logic [IN_W-1:0] raw;
   logic [IN_W-1:0] meta_ff;
   logic [IN_W-1:0] sync_ff;
   logic [IN_W-1:0] sample_ff;
   logic [IN_W-1:0] stable_ff;
   logic [DEB_W-1:0] deb_cnt_ff;
   logic deb_tick;

   // pins are read as-is: right = 1 = on
   assign raw = {flame_present, keypad_press, secondary_sensor_over_sp,
                 primary_sensor_over_sp, primary_sensor_below_sp,
                 proof_of_closure_input, level_shutdown_active, shutdown_active,
                 remote_on, local_on, primary_sensor_range_sel,
                 secondary_sensor_enable, secondary_sensor_range_sel,
                 display_dim_sel, pilot_continuous_sel, shutdown_latch_sel,
                 overtemp_latch_sel, power_fail_latch_sel};

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         meta_ff <= burner_option_pkg::IN_RST;
         sync_ff <= burner_option_pkg::IN_RST;
      end else if (clk_en) begin
         meta_ff <= raw;
         sync_ff <= meta_ff;
      end
   end

   assign deb_tick = at_limit(64'(deb_cnt_ff), DEBOUNCE_CYCLES);

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         deb_cnt_ff <= '0;
      end else if (clk_en) begin
         deb_cnt_ff <= deb_tick ? '0 : deb_cnt_ff + DEB_W'(1);
      end
   end

   // level taken after two equal samples
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sample_ff <= burner_option_pkg::IN_RST;
         stable_ff <= burner_option_pkg::IN_RST;
      end else if (clk_en && deb_tick) begin
         sample_ff <= sync_ff;
         for (int i = 0; i < IN_W; i++) begin
            if (sample_ff[i] == sync_ff[i]) begin
               stable_ff[i] <= sync_ff[i];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register file

   logic [burner_option_pkg::IRQ_W-1:0] irq_status_ff;
   logic [burner_option_pkg::IRQ_W-1:0] irq_enable_ff;
   logic [burner_option_pkg::IRQ_W-1:0] irq_event;
   logic remote_run_ff;
   logic [31:0] nxt_rdata;
   burner_option_pkg::ctrl_state_e state_ff;
   burner_option_pkg::ctrl_state_e nxt_state;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         remote_run_ff <= burner_option_pkg::CTRL_REMOTE_RUN_RST;
         irq_enable_ff <= burner_option_pkg::IRQ_ENABLE_RST;
      end else if (clk_en) begin
         if (reg_hit(reg_wr, reg_addr, burner_option_pkg::REG_CONTROL)) begin
            remote_run_ff <= reg_wdata[burner_option_pkg::CTRL_REMOTE_RUN];
         end
         if (reg_hit(reg_wr, reg_addr, burner_option_pkg::REG_IRQ_ENABLE)) begin
            irq_enable_ff <= reg_wdata[burner_option_pkg::IRQ_W-1:0];
         end
      end
   end

   // event beats same-cycle clear
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         irq_status_ff <= '0;
      end else if (clk_en) begin
         if (reg_hit(reg_wr, reg_addr, burner_option_pkg::REG_IRQ_CLEAR)) begin
            irq_status_ff <= (irq_status_ff & ~reg_wdata[burner_option_pkg::IRQ_W-1:0])
                             | irq_event;
         end else begin
            irq_status_ff <= irq_status_ff | irq_event;
         end
      end
   end

   always_comb begin
      nxt_rdata = '0;
      unique case (reg_addr)
         burner_option_pkg::REG_STATUS: begin
            nxt_rdata[burner_option_pkg::ST_STATE_LSB +: 6] = state_ff;
            nxt_rdata[burner_option_pkg::ST_PERMIT] = ignition_permit;
            nxt_rdata[burner_option_pkg::ST_PILOT] = pilot_solenoid_en;
            nxt_rdata[burner_option_pkg::ST_DIM] = display_dim;
            nxt_rdata[burner_option_pkg::ST_SW_LSB +: burner_option_pkg::SW_W] =
               stable_ff[burner_option_pkg::SW_W-1:0];
         end
         burner_option_pkg::REG_IRQ_STATUS: nxt_rdata[burner_option_pkg::IRQ_W-1:0] = irq_status_ff;
         burner_option_pkg::REG_IRQ_ENABLE: nxt_rdata[burner_option_pkg::IRQ_W-1:0] = irq_enable_ff;
         burner_option_pkg::REG_CONTROL: nxt_rdata[burner_option_pkg::CTRL_REMOTE_RUN] = remote_run_ff;
         default: nxt_rdata = '0;
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         reg_rdata <= '0;
         irq <= 1'b0;
      end else if (clk_en) begin
         reg_rdata <= reg_rd ? nxt_rdata : '0;
         irq <= |(irq_status_ff & irq_enable_ff);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // restart control

   logic sel_pf;
   logic sel_ht;
   logic sel_sd;
   logic start_on;
   logic overtemp;
   logic sd_any;
   logic all_clear;
   logic saw_off_ff;

   assign sel_pf = stable_ff[burner_option_pkg::IN_PF_LATCH];
   assign sel_ht = stable_ff[burner_option_pkg::IN_OVERTEMP_LATCH_SEL];
   assign sel_sd = stable_ff[burner_option_pkg::IN_SHUTDOWN_LATCH_SEL];
   // any start source off counts as off
   assign start_on = stable_ff[burner_option_pkg::IN_LOCAL_ON]
                     && stable_ff[burner_option_pkg::IN_REMOTE_ON] && remote_run_ff;
   assign overtemp = stable_ff[burner_option_pkg::IN_SEC_EN]
                     ? stable_ff[burner_option_pkg::IN_SEC_OVER]
                     : stable_ff[burner_option_pkg::IN_PRI_OVER];
   assign sd_any = stable_ff[burner_option_pkg::IN_SHUTDOWN]
                   || stable_ff[burner_option_pkg::IN_LEVEL_SD];
   assign all_clear = !sd_any && !overtemp && stable_ff[burner_option_pkg::IN_POC]
                      && start_on && !other_fault;

   // release needs off, then on
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         saw_off_ff <= 1'b0;
      end else if (clk_en) begin
         if (state_ff inside {burner_option_pkg::ST_PF_LATCH, burner_option_pkg::ST_OVERTEMP_LATCH_SEL,
                              burner_option_pkg::ST_SHUTDOWN_LATCH_SEL}) begin
            if (!start_on) begin
               saw_off_ff <= 1'b1;
            end
         end else begin
            saw_off_ff <= 1'b0;
         end
      end
   end

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         burner_option_pkg::ST_POWERUP: begin
            if (powerup_done) begin
               nxt_state = sel_pf ? burner_option_pkg::ST_PF_LATCH
                                  : burner_option_pkg::ST_WAIT;
            end
         end
         burner_option_pkg::ST_WAIT, burner_option_pkg::ST_RUN: begin
            if (overtemp && sel_ht) begin
               nxt_state = burner_option_pkg::ST_OVERTEMP_LATCH_SEL;
            end else if (sd_any && sel_sd) begin
               nxt_state = burner_option_pkg::ST_SHUTDOWN_LATCH_SEL;
            end else if (all_clear) begin
               nxt_state = burner_option_pkg::ST_RUN;
            end else begin
               nxt_state = burner_option_pkg::ST_WAIT;
            end
         end
         burner_option_pkg::ST_PF_LATCH, burner_option_pkg::ST_OVERTEMP_LATCH_SEL,
         burner_option_pkg::ST_SHUTDOWN_LATCH_SEL: begin
            if (saw_off_ff && start_on) begin
               nxt_state = burner_option_pkg::ST_WAIT;
            end
         end
         default: nxt_state = burner_option_pkg::ST_POWERUP;
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_ff <= burner_option_pkg::ST_POWERUP;
      end else if (clk_en) begin
         state_ff <= nxt_state;
      end
   end

   always_comb begin
      irq_event = '0;
      if (nxt_state != state_ff) begin
         irq_event[burner_option_pkg::IRQ_PF] = (nxt_state == burner_option_pkg::ST_PF_LATCH);
         irq_event[burner_option_pkg::IRQ_HT] = (nxt_state == burner_option_pkg::ST_OVERTEMP_LATCH_SEL);
         irq_event[burner_option_pkg::IRQ_SD] = (nxt_state == burner_option_pkg::ST_SHUTDOWN_LATCH_SEL);
         irq_event[burner_option_pkg::IRQ_RUN] = (nxt_state == burner_option_pkg::ST_RUN);
      end
      irq_event = clk_en ? irq_event : '0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // pilot and range outputs

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ignition_permit <= 1'b0;
         pilot_solenoid_en <= 1'b0;
      end else if (clk_en) begin
         ignition_permit <= (nxt_state == burner_option_pkg::ST_RUN);
         if (stable_ff[burner_option_pkg::IN_PILOT_MODE]) begin
            pilot_solenoid_en <= (nxt_state == burner_option_pkg::ST_RUN);
         end else begin
            pilot_solenoid_en <= (nxt_state == burner_option_pkg::ST_RUN)
                                 && stable_ff[burner_option_pkg::IN_PRI_BELOW];
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         primary_narrow_range <= 1'b0;
         secondary_narrow_range <= 1'b0;
         secondary_sensor_used <= 1'b1;
      end else if (clk_en) begin
         primary_narrow_range <= stable_ff[burner_option_pkg::IN_PRI_RANGE];
         secondary_narrow_range <= stable_ff[burner_option_pkg::IN_SEC_RANGE];
         secondary_sensor_used <= stable_ff[burner_option_pkg::IN_SEC_EN];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // flash codes

   logic [FL_W-1:0] flash_cnt_ff;
   logic blink_ff;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         flash_cnt_ff <= '0;
         blink_ff <= 1'b0;
      end else if (clk_en) begin
         if (at_limit(64'(flash_cnt_ff), FLASH_HALF_CYCLES)) begin
            flash_cnt_ff <= '0;
            blink_ff <= !blink_ff;
         end else begin
            flash_cnt_ff <= flash_cnt_ff + FL_W'(1);
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         power_fail_flash_code <= 1'b0;
         overtemp_flash_code <= 1'b0;
         shutdown_flash_code <= 1'b0;
      end else if (clk_en) begin
         power_fail_flash_code <= blink_ff && (state_ff == burner_option_pkg::ST_PF_LATCH);
         overtemp_flash_code <= blink_ff && (state_ff == burner_option_pkg::ST_OVERTEMP_LATCH_SEL);
         shutdown_flash_code <= blink_ff && (state_ff == burner_option_pkg::ST_SHUTDOWN_LATCH_SEL);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // display power save

   logic [DIM_W-1:0] idle_cnt_ff;
   logic key_prev_ff;
   logic key_rise;
   logic idle_done;

   assign key_rise = stable_ff[burner_option_pkg::IN_KEYPAD] && !key_prev_ff;
   assign idle_done = at_limit(64'(idle_cnt_ff), DIM_CYCLES);

   // saturates: long idle never wraps to bright
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         key_prev_ff <= 1'b0;
         idle_cnt_ff <= '0;
      end else if (clk_en) begin
         key_prev_ff <= stable_ff[burner_option_pkg::IN_KEYPAD];
         if (key_rise) begin
            idle_cnt_ff <= '0;
         end else if (!idle_done) begin
            idle_cnt_ff <= idle_cnt_ff + DIM_W'(1);
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         display_dim <= 1'b0;
         sensor_select_led_en <= 1'b1;
         ignition_led_on <= 1'b0;
      end else if (clk_en) begin
         // switch off: never dims
         display_dim <= stable_ff[burner_option_pkg::IN_DIM_SEL] && idle_done
                        && !key_rise;
         sensor_select_led_en <= !(stable_ff[burner_option_pkg::IN_DIM_SEL] && idle_done
                                   && !key_rise);
         ignition_led_on <= stable_ff[burner_option_pkg::IN_FLAME];
      end
   end

endmodule

/* File: tb/burner_option_checker.sv */
`timescale 1ns/1ps
module burner_option_checker #(
   parameter longint DIM_CYCLES = 200,
   parameter longint FLASH_HALF_CYCLES = 8
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic keypad_press,
   input wire logic other_fault,
   input wire logic powerup_done,
   input wire logic primary_sensor_range_sel,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic ignition_permit,
   input wire logic pilot_solenoid_en,
   input wire logic display_dim,
   input wire logic sensor_select_led_en,
   input wire logic power_fail_flash_code,
   input wire logic overtemp_flash_code,
   input wire logic shutdown_flash_code,
   input wire logic primary_narrow_range
);
   logic [15:0] idle_ff;
   logic [7:0] blink_ff;
   logic key_ff;
   logic [2:0] fl;
   assign fl = {shutdown_flash_code, overtemp_flash_code, power_fail_flash_code};
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // raw key edge leads the debounced one; wraps after 65k cycles
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         idle_ff <= 16'h0000;
         key_ff <= 1'b0;
         blink_ff <= 8'h00;
      end else begin
         key_ff <= keypad_press;
         idle_ff <= (keypad_press && !key_ff) ? 16'h0000 : idle_ff + 16'h0001;
         blink_ff <= (|fl) ? blink_ff + 8'h01 : 8'h00;
      end
   end
   chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
      else $error("rdata not idle");
   chk_dim_leds: assert property (sensor_select_led_en == !display_dim)
      else $error("leds vs dim");
   chk_pilot_permit: assert property (pilot_solenoid_en |-> ignition_permit)
      else $error("pilot no permit");
   chk_flash_stop: assert property (|fl |-> !ignition_permit)
      else $error("flash in permit");
   chk_flash_one: assert property ($onehot0(fl))
      else $error("two flash codes");
   chk_fault_stop: assert property (other_fault [*3] |-> !ignition_permit)
      else $error("permit in fault");
   chk_permit_cause: assert property ($rose(ignition_permit) |->
      powerup_done && !$past(other_fault))
      else $error("permit cause");
   chk_dim_idle: assert property ($rose(display_dim) |-> idle_ff >= DIM_CYCLES - 1)
      else $error("dim early");
   chk_flash_half: assert property (blink_ff <= FLASH_HALF_CYCLES)
      else $error("flash too long");
   chk_range_copy: assert property ($rose(primary_narrow_range) |->
      $past(primary_sensor_range_sel, 3))
      else $error("range no switch");
endmodule

bind burner_option_switch_logic burner_option_checker #(
   .DIM_CYCLES(DIM_CYCLES),
   .FLASH_HALF_CYCLES(FLASH_HALF_CYCLES)
) u_chk (.*);

/* File: tb/option_plant_model.sv */
`timescale 1ns/1ps
module option_plant_model (
   input wire logic clock,
   input wire logic [17:0] want,
   output logic [17:0] pins
);
   logic [17:0] old_ff;
   logic [17:0] prev_ff;
   logic [1:0] bnc_ff = 2'd0;
   // contact bounces back for one cycle
   always @(posedge clock) begin
      if (want !== old_ff) begin
         prev_ff <= old_ff;
         old_ff <= want;
         bnc_ff <= 2'd2;
         pins <= want;
      end else begin
         bnc_ff <= (bnc_ff != 2'd0) ? bnc_ff - 2'd1 : 2'd0;
         pins <= (bnc_ff == 2'd2) ? prev_ff : want;
      end
   end
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic pwr_ok = 1'b0;
   logic fault = 1'b0;
   logic [17:0] want = burner_option_pkg::IN_RST;
   logic [17:0] pins;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic rd_seen = 1'b0;
   logic [31:0] reg_rdata;
   logic irq, permit, pilot, dim, sel_led, flame_led, pf_fl, ht_fl, sd_fl;
   logic pri_nar, sec_nar, sec_used;
   logic [63:0] exp_q[$];
   logic [63:0] nt;
   logic [1:0] v;
   logic [31:0] rnd;
   int compares = 0;
   int miscompares = 0;

   always #10 clock = ~clock;

   option_plant_model u_plant (.clock, .want, .pins);

   burner_option_switch_logic #(.DEBOUNCE_CYCLES(4), .DIM_CYCLES(200),
      .FLASH_HALF_CYCLES(8)) u_dut (.clock, .rst, .clk_en(1'b1),
      .power_fail_latch_sel(pins[0]), .overtemp_latch_sel(pins[1]),
      .shutdown_latch_sel(pins[2]), .pilot_continuous_sel(pins[3]),
      .display_dim_sel(pins[4]), .secondary_sensor_range_sel(pins[5]),
      .secondary_sensor_enable(pins[6]), .primary_sensor_range_sel(pins[7]),
      .local_on(pins[8]), .remote_on(pins[9]), .shutdown_active(pins[10]),
      .level_shutdown_active(pins[11]), .proof_of_closure_input(pins[12]),
      .primary_sensor_below_sp(pins[13]), .primary_sensor_over_sp(pins[14]),
      .secondary_sensor_over_sp(pins[15]), .keypad_press(pins[16]),
      .flame_present(pins[17]), .powerup_done(pwr_ok), .other_fault(fault),
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .irq, .ignition_permit(permit),
      .pilot_solenoid_en(pilot), .display_dim(dim), .sensor_select_led_en(sel_led),
      .ignition_led_on(flame_led), .power_fail_flash_code(pf_fl),
      .overtemp_flash_code(ht_fl), .shutdown_flash_code(sd_fl),
      .primary_narrow_range(pri_nar), .secondary_narrow_range(sec_nar),
      .secondary_sensor_used(sec_used));

   ////////////////////////////////////////////////////////////////////////////
   task test_done();
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task check(logic [31:0] seen, logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task step(int n);
      repeat (n) @(posedge clock);
   endtask

   task wr(logic [7:0] a, logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask

   task rd(logic [7:0] a, logic [31:0] e, logic [31:0] m = 32'hffff_ffff);
      @(posedge clock);
      exp_q.push_back({m, e});
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
   endtask

   task st(logic [5:0] s, logic p = 1'b0, logic pl = 1'b0);
      rd(burner_option_pkg::REG_STATUS, {24'h00_0000, pl, p, s}, 32'h0000_00ff);
   endtask

   // covers sync, two samples, state update
   task sw(int i, logic val);
      @(posedge clock);
      want[i] <= val;
      step(40);
   endtask

   task flash(logic [2:0] on);
      int n, m;
      n = 0;
      m = 0;
      repeat (32) begin
         @(posedge clock);
         n += $countones({sd_fl, ht_fl, pf_fl} & on);
         m += $countones({sd_fl, ht_fl, pf_fl} & ~on);
      end
      check(n, (on != 3'b000) ? 32'h0000_0010 : 32'h0000_0000);
      check(m, 32'h0000_0000);
   endtask

   always @(posedge clock) begin
      if (rd_seen && exp_q.size() > 0) begin
         nt = exp_q.pop_front();
         check(reg_rdata & nt[63:32], nt[31:0]);
      end
      rd_seen <= reg_rd;
   end

   initial begin
      repeat (30000) @(posedge clock);
      miscompares++;
      test_done();
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rnd = $urandom(32'h6063b557);
      step(3);
      rst <= 1'b0;
      rd(burner_option_pkg::REG_IRQ_ENABLE, 32'h0000_0000);
      rd(burner_option_pkg::REG_CONTROL, 32'h0000_0001);
      rd(8'h14, 32'h0000_0000);
      rd(burner_option_pkg::REG_STATUS, 32'h0000_8c01, 32'h0001_fe3f);
      @(posedge clock);
      want <= 18'h2_3346;
      step(40);
      pwr_ok <= 1'b1;
      step(6);
      st(6'h04, 1'b1, 1'b1);
      rd(burner_option_pkg::REG_IRQ_STATUS, 32'h0000_0008, 32'h0000_0008);
      check(irq, 1'b0);
      wr(burner_option_pkg::REG_IRQ_ENABLE, 32'h0000_0008);
      step(3);
      check(irq, 1'b1);
      wr(burner_option_pkg::REG_IRQ_CLEAR, 32'h0000_0008);
      step(3);
      check(irq, 1'b0);
      $display("done: power-up and interrupt");
      sw(burner_option_pkg::IN_PRI_BELOW, 1'b0);
      st(6'h04, 1'b1, 1'b0);
      sw(burner_option_pkg::IN_PILOT_MODE, 1'b1);
      st(6'h04, 1'b1, 1'b1);
      sw(burner_option_pkg::IN_PILOT_MODE, 1'b0);
      sw(burner_option_pkg::IN_PRI_BELOW, 1'b1);
      for (int i = 0; i < 4; i++) begin
         v = i[1:0] ^ rnd[1:0];
         @(posedge clock);
         want <= (want & ~18'h0_00a0) | {10'h000, v[0], 1'b0, v[1], 5'h00};
         step(40);
         check(pri_nar, v[0]);
         check(sec_nar, v[1]);
      end
      @(posedge clock);
      want <= want & ~18'h0_00a0;
      sw(burner_option_pkg::IN_SEC_OVER, 1'b1);
      st(6'h10);
      flash(3'b010);
      sw(burner_option_pkg::IN_SEC_OVER, 1'b0);
      st(6'h10);
      sw(burner_option_pkg::IN_LOCAL_ON, 1'b0);
      sw(burner_option_pkg::IN_LOCAL_ON, 1'b1);
      st(6'h04, 1'b1, 1'b1);
      sw(burner_option_pkg::IN_OVERTEMP_LATCH_SEL, 1'b0);
      sw(burner_option_pkg::IN_SEC_OVER, 1'b1);
      st(6'h02);
      sw(burner_option_pkg::IN_SEC_OVER, 1'b0);
      st(6'h04, 1'b1, 1'b1);
      sw(burner_option_pkg::IN_SEC_EN, 1'b0);
      check(sec_used, 1'b0);
      sw(burner_option_pkg::IN_SEC_OVER, 1'b1);
      st(6'h04, 1'b1, 1'b1);
      sw(burner_option_pkg::IN_PRI_OVER, 1'b1);
      st(6'h02);
      sw(burner_option_pkg::IN_PRI_OVER, 1'b0);
      sw(burner_option_pkg::IN_SEC_OVER, 1'b0);
      sw(burner_option_pkg::IN_SEC_EN, 1'b1);
      $display("done: overtemp");
      sw(burner_option_pkg::IN_SHUTDOWN, 1'b1);
      st(6'h20);
      flash(3'b100);
      sw(burner_option_pkg::IN_SHUTDOWN, 1'b0);
      st(6'h20);
      sw(burner_option_pkg::IN_REMOTE_ON, 1'b0);
      sw(burner_option_pkg::IN_REMOTE_ON, 1'b1);
      st(6'h04, 1'b1, 1'b1);
      sw(burner_option_pkg::IN_SHUTDOWN_LATCH_SEL, 1'b0);
      sw(burner_option_pkg::IN_LEVEL_SD, 1'b1);
      st(6'h02);
      sw(burner_option_pkg::IN_LEVEL_SD, 1'b0);
      st(6'h04, 1'b1, 1'b1);
      @(posedge clock);
      fault <= 1'b1;
      step(4);
      check(permit, 1'b0);
      fault <= 1'b0;
      $display("done: shutdown");
      step(250);
      check(dim, 1'b0);
      sw(burner_option_pkg::IN_DIM_SEL, 1'b1);
      step(220);
      check(dim, 1'b1);
      check(flame_led, 1'b1);
      sw(burner_option_pkg::IN_KEYPAD, 1'b1);
      sw(burner_option_pkg::IN_KEYPAD, 1'b0);
      check(dim, 1'b0);
      sw(burner_option_pkg::IN_DIM_SEL, 1'b0);
      $display("done: display dimming");
      @(posedge clock);
      want[burner_option_pkg::IN_PF_LATCH] <= 1'b1;
      rst <= 1'b1;
      pwr_ok <= 1'b0;
      step(3);
      rst <= 1'b0;
      step(40);
      pwr_ok <= 1'b1;
      step(6);
      st(6'h08);
      flash(3'b001);
      wr(burner_option_pkg::REG_CONTROL, 32'h0000_0000);
      step(6);
      wr(burner_option_pkg::REG_CONTROL, 32'h0000_0001);
      step(6);
      st(6'h04, 1'b1, 1'b1);
      rd(burner_option_pkg::REG_IRQ_STATUS, 32'h0000_0001, 32'h0000_0001);
      step(4);
      $display("done: power-fail latch");
      test_done();
   end
endmodule
